/* logic/arfs_top.sv */
// Reference control, result flags and sequence status of the converter.
// Assumes an Avalon-MM master on I_REF_CLK and a conversion core on the
// same clock that pulses start, done and last for one cycle each.
//
// Chosen here: register access over Avalon-MM.

module arfs_top
    import arfs_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire arfs_core_t I_CORE,
    output arfs_ref_t O_REF,
    output logic [15:0] O_CONTROL_B,
    output logic [7:0] O_INPUT_SEL,
    output logic O_IRQ
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    arfs_state_t s_q;
    arfs_state_t s_d;
    logic req;
    logic acc;
    logic acc_wr;
    logic acc_rd;
    logic [5:0] idx;
    logic [7:0] wb0;
    logic [7:0] wb1;
    logic rd_result;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;

    assign req = I_AVS_READ | I_AVS_WRITE;
    assign idx = I_AVS_ADDRESS[7:2];
    // Transfer completes at the edge where waitrequest is seen low
    assign acc = req & ~s_q.wait_req;
    assign acc_wr = acc & I_AVS_WRITE;
    assign acc_rd = acc & I_AVS_READ;
    assign wb0 = I_AVS_WRITEDATA[7:0];
    assign wb1 = I_AVS_WRITEDATA[15:8];
    assign rd_result = acc_rd & (idx == IDX_RESULT);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        flag_set = 2'h0;
        flag_clr = 2'h0;

        // One wait cycle, then a one-cycle answer
        if (req && s_q.wait_req) begin
            s_d.wait_req = 1'b0;
        end else begin
            s_d.wait_req = 1'b1;
        end

        if (req && s_q.wait_req) begin
            s_d.rdata = 32'h0000_0000;
            unique case (idx)
                IDX_CONTROL_B: s_d.rdata[15:0] = s_q.control_b;
                IDX_SEQ_STATUS: begin
                    s_d.rdata[SEQ_ACT_BIT] = s_q.seq_act;
                    s_d.rdata[3:0] = s_q.seq_ptr;
                end
                IDX_INPUT_SEL: s_d.rdata[7:0] = s_q.input_sel;
                IDX_REF_CTRL: s_d.rdata[7:0] = s_q.ref_ctrl;
                IDX_MASK_CLR,
                IDX_MASK_SET: s_d.rdata[1:0] = s_q.mask;
                IDX_INT_FLAGS: s_d.rdata[1:0] = s_q.flags;
                IDX_RESULT: s_d.rdata[11:0] = s_q.result;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        if (acc_wr && I_AVS_BYTEENABLE[0]) begin
            unique case (idx)
                IDX_CONTROL_B: s_d.control_b[7:0] = wb0;
                IDX_INPUT_SEL: s_d.input_sel = wb0;
                IDX_REF_CTRL: s_d.ref_ctrl = wb0 & REF_CTRL_WMASK;
                IDX_MASK_CLR: s_d.mask = s_q.mask & ~wb0[1:0];
                IDX_MASK_SET: s_d.mask = s_q.mask | wb0[1:0];
                IDX_INT_FLAGS: flag_clr = wb0[1:0];
                default: s_d.control_b = s_q.control_b;
            endcase
        end
        if (acc_wr && I_AVS_BYTEENABLE[1] && idx == IDX_CONTROL_B) begin
            s_d.control_b[15:8] = wb1;
        end

        if (rd_result) begin
            flag_clr[FLAG_RDY_BIT] = 1'b1;
            s_d.unread = 1'b0;
        end

        // New result from the core; a set beats a same-cycle clear
        if (I_CORE.done) begin
            s_d.result = I_CORE.result;
            s_d.unread = 1'b1;
            flag_set[FLAG_RDY_BIT] = 1'b1;
            flag_set[FLAG_OVR_BIT] = s_q.unread & ~rd_result;
        end
        s_d.flags = (s_q.flags & ~flag_clr) | flag_set;

        if (I_CORE.done && s_q.seq_act) begin
            s_d.seq_ptr = s_q.seq_cnt;
            s_d.seq_cnt = s_q.seq_cnt + 4'h1;
            if (I_CORE.last) begin
                s_d.seq_act = 1'b0;
            end
        end
        if (I_CORE.start) begin
            s_d.seq_act = 1'b1;
            s_d.seq_cnt = 4'h0;
        end

        s_d.irq = |(s_d.flags & s_d.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            s_q.control_b <= CONTROL_B_RST;
            s_q.input_sel <= INPUT_SEL_RST;
            s_q.ref_ctrl <= REF_CTRL_RST;
            s_q.flags <= FLAGS_RST;
            s_q.mask <= MASK_RST;
            s_q.result <= 12'h000;
            s_q.unread <= 1'b0;
            s_q.seq_act <= SEQ_STATUS_RST[SEQ_ACT_BIT];
            s_q.seq_ptr <= SEQ_STATUS_RST[3:0];
            s_q.seq_cnt <= 4'h0;
            s_q.wait_req <= 1'b1;
            s_q.rdata <= 32'h0000_0000;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_AVS_READDATA = s_q.rdata;
    assign O_AVS_WAITREQUEST = s_q.wait_req;
    assign O_REF.buf_on = s_q.ref_ctrl[REF_BUF_BIT];
    assign O_REF.range = s_q.ref_ctrl[REF_RANGE_LSB +: 2];
    assign O_REF.sel = s_q.ref_ctrl[REF_SEL_LSB +: 2];
    assign O_CONTROL_B = s_q.control_b;
    assign O_INPUT_SEL = s_q.input_sel;
    assign O_IRQ = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    logic ref_wr;
    logic flag_wr;
    assign ref_wr = acc_wr & I_AVS_BYTEENABLE[0] & (idx == IDX_REF_CTRL);
    assign flag_wr = acc_wr & I_AVS_BYTEENABLE[0] & (idx == IDX_INT_FLAGS);
    logic mask_set_wr;
    logic mask_clr_wr;
    logic ctl_hi_wr;
    assign mask_set_wr = acc_wr & I_AVS_BYTEENABLE[0]
        & (idx == IDX_MASK_SET);
    assign mask_clr_wr = acc_wr & I_AVS_BYTEENABLE[0]
        & (idx == IDX_MASK_CLR);
    assign ctl_hi_wr = acc_wr & I_AVS_BYTEENABLE[1]
        & (idx == IDX_CONTROL_B);

    sequence seq_begin_s;
        I_CORE.start;
    endsequence
    sequence seq_finish_s;
        I_CORE.done && I_CORE.last && s_q.seq_act && !I_CORE.start;
    endsequence
    sequence bus_wait_s;
        req && O_AVS_WAITREQUEST;
    endsequence
    sequence bus_answer_s;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence
    sequence rd_take_s;
        I_AVS_READ && O_AVS_WAITREQUEST;
    endsequence
    sequence seq_hold_s;
        s_q.seq_act && !I_CORE.start && !(I_CORE.done && I_CORE.last);
    endsequence

    ref_select_a: assert property (
        ref_wr |=> O_REF.sel == $past(I_AVS_WRITEDATA[1:0]))
        else $error("reference select not taken from write");
    ref_range_a: assert property (
        ref_wr |=> O_REF.range == $past(I_AVS_WRITEDATA[5:4]))
        else $error("reference range not taken from write");
    ref_buffer_a: assert property (
        ref_wr |=> O_REF.buf_on == $past(I_AVS_WRITEDATA[7]))
        else $error("reference buffer bit not taken from write");
    overrun_set_a: assert property (
        I_CORE.done && s_q.unread && !rd_result |=> s_q.flags[FLAG_OVR_BIT])
        else $error("overrun not flagged");
    overrun_clear_a: assert property (
        flag_wr && I_AVS_WRITEDATA[1] && !(I_CORE.done && s_q.unread)
        |=> !s_q.flags[FLAG_OVR_BIT])
        else $error("overrun not cleared by write of one");
    ready_set_a: assert property (
        I_CORE.done |=> s_q.flags[FLAG_RDY_BIT] && s_q.unread)
        else $error("result ready not flagged");
    ready_read_a: assert property (
        rd_result && !I_CORE.done |=> !s_q.flags[FLAG_RDY_BIT])
        else $error("result read did not clear result ready");
    flag_keep_a: assert property (
        flag_wr && !I_AVS_WRITEDATA[0] && !rd_result && s_q.flags[0]
        |=> s_q.flags[FLAG_RDY_BIT])
        else $error("zero write disturbed result ready");
    seq_begin_a: assert property (
        seq_begin_s |=> s_q.seq_act && s_q.seq_cnt == 4'h0)
        else $error("sequence start not reported");
    seq_finish_a: assert property (
        seq_finish_s |=> !s_q.seq_act)
        else $error("sequence active after last conversion");
    seq_pointer_a: assert property (
        I_CORE.done && s_q.seq_act |=> s_q.seq_ptr == $past(s_q.seq_cnt))
        else $error("sequence pointer wrong");
    irq_level_a: assert property (
        O_IRQ == |(s_q.flags & s_q.mask))
        else $error("interrupt line does not match flags and mask");
    bus_timing_a: assert property (
        bus_wait_s |=> bus_answer_s)
        else $error("bus answer not one cycle after wait");

    // ------------------------------------------------------------
    // Clears, holds, register writes and read-back answers
    // ------------------------------------------------------------
    ready_clear_a: assert property (
        flag_wr && I_AVS_WRITEDATA[0] && !I_CORE.done
        |=> !s_q.flags[FLAG_RDY_BIT])
        else $error("result ready not cleared by write of one");
    overrun_keep_a: assert property (
        flag_wr && !I_AVS_WRITEDATA[1] && s_q.flags[FLAG_OVR_BIT]
        |=> s_q.flags[FLAG_OVR_BIT])
        else $error("zero write disturbed overrun");
    seq_hold_a: assert property (
        seq_hold_s |=> s_q.seq_act)
        else $error("sequence active dropped before last result");
    seq_idle_a: assert property (
        !s_q.seq_act && !I_CORE.start |=> !s_q.seq_act)
        else $error("sequence active without a start");
    pointer_keep_a: assert property (
        !(I_CORE.done && s_q.seq_act) |=> $stable(s_q.seq_ptr))
        else $error("sequence pointer moved without a result");
    status_write_a: assert property (
        acc_wr && idx == IDX_SEQ_STATUS && !I_CORE.start && !I_CORE.done
        |=> $stable(s_q.seq_act) && $stable(s_q.seq_ptr))
        else $error("write reached read-only sequence status");
    mask_set_a: assert property (
        mask_set_wr |=> s_q.mask == ($past(s_q.mask)
            | $past(I_AVS_WRITEDATA[1:0])))
        else $error("mask set write not applied");
    mask_clear_a: assert property (
        mask_clr_wr |=> s_q.mask == ($past(s_q.mask)
            & ~$past(I_AVS_WRITEDATA[1:0])))
        else $error("mask clear write not applied");
    control_high_a: assert property (
        ctl_hi_wr |=> O_CONTROL_B[15:8] == $past(I_AVS_WRITEDATA[15:8]))
        else $error("control upper lane not written");
    read_ref_a: assert property (
        rd_take_s ##0 idx == IDX_REF_CTRL
        |=> O_AVS_READDATA == {24'h0, $past(s_q.ref_ctrl)})
        else $error("reference control read back wrong");
    read_status_a: assert property (
        rd_take_s ##0 idx == IDX_SEQ_STATUS |=> O_AVS_READDATA
            == {24'h0, $past(s_q.seq_act), 3'h0, $past(s_q.seq_ptr)})
        else $error("sequence status read back wrong");

endmodule // arfs_top

/* logic/arfs_pkg.sv */
// Package of the converter reference, flag and sequence control block.
// Assumes one 40 MHz clock shared with the bus and the conversion core.
package arfs_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CONTROL_B = 6'h02;
    localparam logic [5:0] IDX_SEQ_STATUS = 6'h08;
    localparam logic [5:0] IDX_INPUT_SEL = 6'h09;
    localparam logic [5:0] IDX_REF_CTRL = 6'h0A;
    localparam logic [5:0] IDX_MASK_CLR = 6'h0C;
    localparam logic [5:0] IDX_MASK_SET = 6'h0D;
    localparam logic [5:0] IDX_INT_FLAGS = 6'h0E;
    localparam logic [5:0] IDX_RESULT = 6'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int REF_SEL_LSB = 0;
    localparam int REF_RANGE_LSB = 4;
    localparam int REF_BUF_BIT = 7;
    localparam logic [7:0] REF_CTRL_WMASK = 8'hB3;
    localparam int FLAG_RDY_BIT = 0;
    localparam int FLAG_OVR_BIT = 1;
    localparam int SEQ_ACT_BIT = 7;
    localparam logic [15:0] CONTROL_B_RST = 16'h0000;
    localparam logic [7:0] SEQ_STATUS_RST = 8'h00;
    localparam logic [7:0] INPUT_SEL_RST = 8'h00;
    localparam logic [7:0] REF_CTRL_RST = 8'h00;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // ------------------------------------------------------------
    // Reference source codes
    // ------------------------------------------------------------
    localparam logic [1:0] REFSRC_BANDGAP = 2'h0;
    localparam logic [1:0] REFSRC_EXT_PIN = 2'h1;
    localparam logic [1:0] REFSRC_DAC = 2'h2;
    localparam logic [1:0] REFSRC_SUPPLY = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic done;
        logic last;
        logic [11:0] result;
    } arfs_core_t;

    typedef struct packed {
        logic buf_on;
        logic [1:0] range;
        logic [1:0] sel;
    } arfs_ref_t;

    typedef struct packed {
        logic [15:0] control_b;
        logic [7:0] input_sel;
        logic [7:0] ref_ctrl;
        logic [1:0] flags;
        logic [1:0] mask;
        logic [11:0] result;
        logic unread;
        logic seq_act;
        logic [3:0] seq_ptr;
        logic [3:0] seq_cnt;
        logic wait_req;
        logic [31:0] rdata;
        logic irq;
    } arfs_state_t;

endpackage

/* verif/arfs_core_model.sv */
// Behavioural conversion core feeding the block's core group.
// Assumes the block samples start, done and last on rising clock edges.
module arfs_core_model
    import arfs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [3:0] i_len,
    input wire logic [3:0] i_gap,
    input wire logic [11:0] i_data,
    output arfs_core_t o_core,
    output logic o_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] k_q;
    logic [3:0] cnt_q;
    initial begin
        o_core = '0;
        o_busy = 1'b0;
        k_q = 4'h0;
        cnt_q = 4'h0;
    end
    // Result lines toggle outside done so stale data never looks valid
    always @(posedge i_clk) begin
        o_core.start <= 1'b0;
        o_core.done <= 1'b0;
        o_core.last <= 1'b0;
        o_core.result <= ~o_core.result;
        if (i_go && !o_busy) begin
            o_core.start <= 1'b1;
            o_busy <= 1'b1;
            k_q <= 4'h0;
            cnt_q <= i_gap;
        end else if (o_busy && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (o_busy) begin
            o_core.done <= 1'b1;
            o_core.result <= i_data + 12'(k_q);
            o_core.last <= (k_q + 4'h1 == i_len);
            o_busy <= (k_q + 4'h1 != i_len);
            k_q <= k_q + 4'h1;
            cnt_q <= i_gap;
        end
    end
endmodule // arfs_core_model

/* verif/testbench.sv */
// Self-checking bench of the reference, flag and sequence block.
// Assumes the core model stands on the far side on the same clock.
module testbench import arfs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, av_rd, av_wr, av_wait, irq, go, busy;
    logic [7:0] av_a, w, in_sel;
    logic [31:0] av_wd, av_rdata, lfsr_q;
    logic [15:0] ctl_b;
    logic [3:0] len, gap, be;
    logic [11:0] data;
    logic [63:0] e;
    logic [63:0] q[$];
    arfs_core_t core;
    arfs_ref_t ref_o;
    int fails, comparisons;

    arfs_top uut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(av_a),
        .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd),
        .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(av_rdata),
        .O_AVS_WAITREQUEST(av_wait), .I_CORE(core), .O_REF(ref_o),
        .O_CONTROL_B(ctl_b), .O_INPUT_SEL(in_sel), .O_IRQ(irq));
    arfs_core_model core_m (.i_clk(clk), .i_go(go), .i_len(len),
        .i_gap(gap), .i_data(data), .o_core(core), .o_busy(busy));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [5:0] i, logic [31:0] d);
        int n;
        n = 0;
        av_a <= {i, 2'b00};
        av_wd <= d;
        av_wr <= wr;
        av_rd <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 40);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        if (n >= 40) begin
            fails++;
            test_done();
        end
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] i, logic [31:0] x, logic [31:0] m);
        q.push_back({m, x});
        bus(1'b0, i, 32'h0);
    endtask

    task automatic run(input logic [3:0] l, input logic [3:0] g);
        int n;
        lfsr_q = lfsr(lfsr_q);
        len <= l;
        gap <= g;
        data <= lfsr_q[11:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        n = 0;
        while ((busy || n == 0) && n < 300) begin
            if (n == 1)
                rd(IDX_SEQ_STATUS, 32'h80, 32'h80);
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            fails++;
            test_done();
        end
        repeat (3) @(posedge clk);
    endtask

    // Read data are compared at the edge where the read completes
    always @(posedge clk) begin
        if (av_rd && av_wait === 1'b0) begin
            e = q.pop_front();
            check(av_rdata & e[63:32], e[31:0]);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, go, av_rd, av_wr, len, gap, data, av_a, av_wd} = '0;
        rst = 1'b1;
        be = 4'hF;
        lfsr_q = 32'hD599;
        fails = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        check(32'({av_wait, irq}), 32'h2);
        rst <= 1'b0;
        @(posedge clk);
        rd(IDX_CONTROL_B, 32'h0, 32'hFFFF);
        rd(IDX_SEQ_STATUS, 32'h0, 32'hFF);
        rd(IDX_INPUT_SEL, 32'h0, 32'hFF);
        rd(IDX_REF_CTRL, 32'h0, 32'hFF);
        rd(IDX_MASK_SET, 32'h0, 32'h3);
        rd(IDX_INT_FLAGS, 32'h0, 32'h3);
        for (int s = 0; s < 4; s++) begin
            lfsr_q = lfsr(lfsr_q);
            w = {s[0] ? lfsr_q[7] : 1'b1, lfsr_q[6:2], 2'(s)};
            bus(1'b1, IDX_REF_CTRL, {24'h0, w});
            rd(IDX_REF_CTRL, {24'h0, w & REF_CTRL_WMASK}, 32'hFF);
            check(32'(ref_o), 32'({w[7], w[5:4], w[1:0]}));
        end
        lfsr_q = lfsr(lfsr_q);
        bus(1'b1, IDX_CONTROL_B, lfsr_q);
        rd(IDX_CONTROL_B, {16'h0, lfsr_q[15:0]}, 32'hFFFFFFFF);
        bus(1'b1, IDX_INPUT_SEL, lfsr_q);
        rd(IDX_INPUT_SEL, {24'h0, lfsr_q[7:0]}, 32'hFFFFFFFF);
        check({in_sel, 8'h0, ctl_b}, {lfsr_q[7:0], 8'h0, lfsr_q[15:0]});
        be <= 4'h2;
        bus(1'b1, IDX_CONTROL_B, ~lfsr_q);
        be <= 4'hF;
        rd(IDX_CONTROL_B, {16'h0, ~lfsr_q[15:8], lfsr_q[7:0]}, 32'hFFFFFFFF);
        bus(1'b1, 6'h3F, lfsr_q);
        rd(6'h3F, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, IDX_SEQ_STATUS, 32'hFF);
        rd(IDX_SEQ_STATUS, 32'h0, 32'hFF);
        bus(1'b1, IDX_MASK_SET, 32'h3);
        run(4'h3, 4'hA);
        rd(IDX_SEQ_STATUS, 32'h02, 32'hFF);
        rd(IDX_INT_FLAGS, 32'h3, 32'h3);
        check(32'(irq), 32'h1);
        bus(1'b1, IDX_INT_FLAGS, 32'h0);
        rd(IDX_INT_FLAGS, 32'h3, 32'h3);
        bus(1'b1, IDX_INT_FLAGS, 32'h2);
        rd(IDX_INT_FLAGS, 32'h1, 32'h3);
        rd(IDX_RESULT, 32'(12'(data + 12'h2)), 32'hFFF);
        rd(IDX_INT_FLAGS, 32'h0, 32'h3);
        check(32'(irq), 32'h0);
        bus(1'b1, IDX_MASK_CLR, 32'h1);
        rd(IDX_MASK_SET, 32'h2, 32'h3);
        run(4'h1, 4'h1);
        rd(IDX_INT_FLAGS, 32'h1, 32'h3);
        check(32'(irq), 32'h0);
        bus(1'b1, IDX_INT_FLAGS, 32'h1);
        rd(IDX_INT_FLAGS, 32'h0, 32'h3);
        test_done();
    end
endmodule // testbench
